//--- hw/zone_checker_regs.svh
// Purpose: Constants for the zone write pointer checker.
// Assumes: Zones are equal in size and laid out from block zero upward.
// Notes:   Sense key and additional sense values follow common block command encodings.
`ifndef ZONE_CHECKER_REGS_SVH
`define ZONE_CHECKER_REGS_SVH
`define ZC_SENSE_NONE        4'h0
`define ZC_SENSE_ILLEGAL     4'h5
`define ZC_SENSE_ABORTED     4'hB
`define ZC_ASC_NONE          16'h0000
`define ZC_ASC_UNALIGNED     16'h2104
`define ZC_ASC_WR_BOUNDARY   16'h2105
`define ZC_ASC_INVALID_DATA  16'h2106
`define ZC_ASC_RD_BOUNDARY   16'h2107
`define ZC_ASC_NO_RESOURCES  16'h550E
`define ZC_INIT_STATE        3'h0
`endif

//--- hw/zone_checker_pkg.sv
// Purpose: Types shared by the zone checker modules.
// Assumes: Nothing beyond the constants header.
// Notes:   Condition codes match the zone condition field values of a report.
package zone_checker_pkg;
	typedef enum logic [2:0] {
		zone_state_empty       = 3'h1,
		zone_state_auto_opened = 3'h2,
		zone_state_host_opened = 3'h3,
		zone_state_closed      = 3'h4,
		zone_state_full        = 3'h5
	} zone_state_t;
	typedef enum logic [2:0] {
		op_read   = 3'h0,
		op_write  = 3'h1,
		op_open   = 3'h2,
		op_close  = 3'h3,
		op_finish = 3'h4,
		op_reset  = 3'h5,
		op_report = 3'h6
	} zone_op_t;
	typedef enum logic [1:0] {
		ctl_idle  = 2'h0,
		ctl_fetch = 2'h1,
		ctl_check = 2'h2,
		ctl_commit = 2'h3
	} ctl_state_t;
endpackage

//--- hw/zone_store_if.sv
`timescale 1ns/100ps
// Purpose: Carrier between the checker control and the zone table.
// Assumes: One read and one write per clock.
// Notes:   Read data appears one clock after the address.
interface zone_store_if #(parameter int ZW = 4, parameter int AW = 16);
	import zone_checker_pkg::*;
	logic [ZW-1:0] rd_zone;
	zone_state_t   rd_state;
	logic [AW-1:0] rd_wp;
	logic          wr_en;
	logic [ZW-1:0] wr_zone;
	zone_state_t   wr_state;
	logic [AW-1:0] wr_wp;
	modport ctl (output rd_zone, wr_en, wr_zone, wr_state, wr_wp, input rd_state, rd_wp);
	modport mem (input rd_zone, wr_en, wr_zone, wr_state, wr_wp, output rd_state, rd_wp);
endinterface

//--- hw/zone_table.sv
`timescale 1ns/100ps
// Purpose: Per zone condition and write pointer storage.
// Assumes: Power on image is loaded through the preload port before use.
// Notes:   Contents survive the logic reset, as zone state must persist.
module zone_table
	import zone_checker_pkg::*;
#(
	parameter int ZONES = 16,
	parameter int ZW    = 4,
	parameter int AW    = 16
) (
	input  wire logic  i_clk,
	zone_store_if.mem  store
);
	zone_state_t   state_mem [ZONES];
	logic [AW-1:0] wp_mem    [ZONES];

	// No reset here on purpose: a reset must not forget the zones.
	always_ff @(posedge i_clk) begin
		if (store.wr_en) begin
			state_mem[store.wr_zone] <= store.wr_state;
			wp_mem[store.wr_zone]    <= store.wr_wp;
		end
		store.rd_state <= state_mem[store.rd_zone];
		store.rd_wp    <= wp_mem[store.rd_zone];
	end
endmodule

//--- hw/zone_write_pointer_checker.sv
// Purpose: Zone condition machine and write pointer checks for sequential zones.
// Assumes: Zones are 2**ZBITS blocks; zones at or above SEQ_FIRST are sequential.
// Notes:   One command at a time; the result pulses o_done with sense and descriptor.
// Behaviour
// - Open command moves empty zone host-opened.
// - Auto-opened zone reports its condition, valid pointer.
// - Reset, or close at start, empties open zone.
// - Close with written blocks moves zone closed.
// - Open moves auto-opened or closed host-opened.
// - Finish or filling write makes zone full.
// - Host-opened reports condition; open again harmless.
// - Closed reports condition; close again harmless.
// - Write reopens closed, finish fills it; reset empties.
// - Full: pointer invalid; close, finish harmless.
// - Writes start at pointer; pointer advances.
// - Only reset makes invalid pointer valid.
// - Non-sequential resource flag reported as zero.
// - Open limit reached rejects write to empty.
// - Read below pointer in one zone proceeds.
// - Misplaced or unaligned write end is rejected.
// - Write crossing zones is a boundary violation.
// - Read past pointer: flag picks pattern or error.
// - Cross-zone read needs flag and sequential blocks.
// - Sense information carries the zone's pointer.
// - Write into sequential from outside is rejected.
// - Read into sequential from outside is rejected.
// - Write command moves empty zone auto-opened.
// - Power-on state follows the full flag, else the stored pointer.
`timescale 1ns/100ps
`include "zone_checker_regs.svh"
module zone_write_pointer_checker
	import zone_checker_pkg::*;
#(
	parameter int ZBITS     = 8,
	parameter int ZW        = 4,
	parameter int SEQ_FIRST = 1,
	parameter int PB_LOG    = 3,
	parameter int MAX_OPEN  = 4
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_cmd_valid,
	input  wire logic [2:0]        i_cmd_op,
	input  wire logic [ZBITS+ZW-1:0] i_cmd_lba,
	input  wire logic [ZBITS+ZW-1:0] i_cmd_count,
	input  wire logic              i_unrestricted_read_flag,
	input  wire logic              i_preload_valid,
	input  wire logic [ZW-1:0]     i_preload_zone,
	input  wire logic [ZBITS+ZW-1:0] i_preload_wp,
	input  wire logic              i_preload_full,
	output logic                   o_cmd_ready,
	output logic                   o_done,
	output logic                   o_check_condition,
	output logic [3:0]             o_sense_key,
	output logic [15:0]            o_sense_asc,
	output logic [ZBITS+ZW-1:0]    o_sense_info,
	output logic                   o_read_go,
	output logic                   o_read_pattern,
	output logic                   o_write_go,
	output logic [2:0]             o_zone_condition,
	output logic [ZBITS+ZW-1:0]    o_zone_wp,
	output logic                   o_zone_wp_valid,
	output logic                   o_nonsequential_resource_flag,
	output logic [ZW:0]            o_open_count
);
	localparam int AW = ZBITS + ZW;

	logic          rst_meta;
	logic          rst_sync;
	logic          ur_meta;
	logic          ur_sync;
	ctl_state_t    ctl;
	zone_op_t      op;
	logic [AW-1:0] lba;
	logic [AW-1:0] last;
	logic [ZW:0]   open_count;

	zone_store_if #(.ZW(ZW), .AW(AW)) store ();

	zone_table #(.ZONES(1 << ZW), .ZW(ZW), .AW(AW)) u_table (
		.i_clk (i_clk),
		.store (store)
	);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// The flag is fixed at manufacture but arrives on a pin, so it is synchronised.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			ur_meta <= 1'b0;
			ur_sync <= 1'b0;
		end else begin
			ur_meta <= i_unrestricted_read_flag;
			ur_sync <= ur_meta;
		end
	end

	// Address decode of the command held from ctl_fetch through ctl_commit.
	wire [ZW-1:0]  start_zone = lba[AW-1:ZBITS];
	wire [ZW-1:0]  end_zone   = last[AW-1:ZBITS];
	wire           start_seq  = 32'(start_zone) >= SEQ_FIRST;
	wire           end_seq    = 32'(end_zone) >= SEQ_FIRST;
	wire           same_zone  = start_zone == end_zone;
	wire [AW-1:0]  zone_first = {start_zone, {ZBITS{1'b0}}};
	wire [AW-1:0]  zone_last  = {start_zone, {ZBITS{1'b1}}};
	wire           aligned_end = &last[PB_LOG-1:0];
	zone_state_t   cur_state;
	wire [AW-1:0]  cur_wp     = store.rd_wp;
	wire           is_empty   = cur_state == zone_state_empty;
	wire           is_open    = cur_state == zone_state_auto_opened
				 || cur_state == zone_state_host_opened;
	wire           is_full    = cur_state == zone_state_full;
	wire           wp_at_first = cur_wp == zone_first;
	wire           limit_hit  = MAX_OPEN != 0 && 32'(open_count) == MAX_OPEN;

	assign cur_state = store.rd_state;

	// Write classification.
	wire wr_outside  = !start_seq && end_seq;
	wire wr_cross    = start_seq && !same_zone;
	wire wr_unalign  = start_seq && same_zone
			 && (is_full || lba != cur_wp || !aligned_end);
	wire wr_noroom   = start_seq && same_zone && !wr_unalign
			 && is_empty && limit_hit;
	wire wr_ok       = !wr_outside && !wr_cross && !wr_unalign && !wr_noroom;
	wire wr_fills    = last == zone_last;

	// Read classification.
	wire rd_outside  = !start_seq && end_seq;
	wire rd_cross    = start_seq && !same_zone;
	wire rd_cross_ok = rd_cross && ur_sync;
	wire rd_past     = start_seq && same_zone && !is_full && last >= cur_wp;
	wire rd_bad_data = rd_past && !ur_sync;
	wire rd_pattern  = (rd_past && ur_sync) || rd_cross_ok;
	wire rd_ok       = !rd_outside && !(rd_cross && !ur_sync) && !rd_bad_data;

	// Next zone condition and pointer for a successful command.
	zone_state_t   next_state;
	logic [AW-1:0] next_wp;
	logic          next_write;
	always_comb begin
		next_state = cur_state;
		next_wp    = cur_wp;
		next_write = 1'b0;
		unique case (op)
			op_write: begin
				if (wr_ok && start_seq) begin
					next_write = 1'b1;
					next_wp    = last + AW'(1);
					if (wr_fills) begin
						next_state = zone_state_full;
					end else if (is_empty || cur_state == zone_state_closed) begin
						next_state = zone_state_auto_opened;
					end
				end
			end
			op_open: begin
				if (start_seq && !is_full) begin
					next_write = 1'b1;
					next_state = zone_state_host_opened;
				end
			end
			op_close: begin
				if (start_seq && is_open) begin
					next_write = 1'b1;
					next_state = wp_at_first ? zone_state_empty
						     : zone_state_closed;
				end
			end
			op_finish: begin
				if (start_seq && !is_full) begin
					next_write = 1'b1;
					next_state = zone_state_full;
				end
			end
			op_reset: begin
				if (start_seq) begin
					next_write = 1'b1;
					next_state = zone_state_empty;
					next_wp    = zone_first;
				end
			end
			default: begin
				next_write = 1'b0;
			end
		endcase
	end

	// Open zone accounting; the count moves only when a zone enters or leaves an open state.
	// A refused command changes no count, as next_write stays low for it.
	wire        was_open  = is_open;
	wire        will_open = next_state == zone_state_auto_opened
			     || next_state == zone_state_host_opened;
	wire        commit    = ctl == ctl_commit;
	wire        count_up  = commit && next_write && !was_open && will_open;
	wire        count_dn  = commit && next_write && was_open && !will_open;
	wire [ZW:0] next_open_count = count_up ? open_count + (ZW+1)'(1)
				    : count_dn ? open_count - (ZW+1)'(1)
				    : open_count;

	// Sense selection. Boundary errors outrank alignment, and alignment outranks the open
	// limit, so a misplaced write never reports a resource shortage.
	logic [3:0]  next_key;
	logic [15:0] next_asc;
	always_comb begin
		next_key = `ZC_SENSE_NONE;
		next_asc = `ZC_ASC_NONE;
		if (op == op_write) begin
			if (wr_outside || wr_cross) begin
				next_key = `ZC_SENSE_ILLEGAL;
				next_asc = `ZC_ASC_WR_BOUNDARY;
			end else if (wr_unalign) begin
				next_key = `ZC_SENSE_ILLEGAL;
				next_asc = `ZC_ASC_UNALIGNED;
			end else if (wr_noroom) begin
				next_key = `ZC_SENSE_ABORTED;
				next_asc = `ZC_ASC_NO_RESOURCES;
			end
		end else if (op == op_read) begin
			if (rd_outside || rd_bad_data) begin
				next_key = `ZC_SENSE_ILLEGAL;
				next_asc = `ZC_ASC_INVALID_DATA;
			end else if (rd_cross && !ur_sync) begin
				next_key = `ZC_SENSE_ILLEGAL;
				next_asc = `ZC_ASC_RD_BOUNDARY;
			end
		end
	end

	// Result decode. Every pulse is registered on the commit step, at the same edge as the
	// table write, so a result never leads the stored state.
	wire next_ready    = ctl == ctl_idle && !i_cmd_valid;
	wire next_check    = commit && next_key != `ZC_SENSE_NONE;
	wire next_read_go  = commit && op == op_read && rd_ok;
	wire next_read_pat = next_read_go && rd_pattern;
	wire next_write_go = commit && op == op_write && wr_ok;

	// The pins address the table only while idle, so a host that drops its address
	// after the command is taken still gets the right zone.
	assign store.rd_zone  = ctl == ctl_idle ? i_cmd_lba[AW-1:ZBITS] : start_zone;
	assign store.wr_en    = (ctl == ctl_commit && next_write) || i_preload_valid;
	assign store.wr_zone  = i_preload_valid ? i_preload_zone : start_zone;
	// Power-on image: full when i_preload_full is set, otherwise state follows where the pointer stands.
	assign store.wr_state = !i_preload_valid ? next_state
			      : i_preload_full ? zone_state_full
			      : i_preload_wp[ZBITS-1:0] == '0 ? zone_state_empty
			      : zone_state_closed;
	assign store.wr_wp    = i_preload_valid ? i_preload_wp : next_wp;

	// Command intake holds the start and the last block for the whole command, so the
	// decode above never sees the pins change under it.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			ctl        <= ctl_idle;
			op         <= op_read;
			lba        <= '0;
			last       <= '0;
			open_count <= '0;
		end else begin
			unique case (ctl)
				ctl_idle: begin
					if (i_cmd_valid) begin
						op   <= zone_op_t'(i_cmd_op);
						lba  <= i_cmd_lba;
						last <= i_cmd_lba + i_cmd_count - AW'(1);
						ctl  <= ctl_fetch;
					end
				end
				ctl_fetch: ctl <= ctl_check;
				ctl_check: ctl <= ctl_commit;
				ctl_commit: begin
					open_count <= next_open_count;
					ctl        <= ctl_idle;
				end
			endcase
		end
	end

	// Handshake and result pulses; the table is updated at the same edge.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_cmd_ready       <= 1'b0;
			o_done            <= 1'b0;
			o_check_condition <= 1'b0;
			o_read_go         <= 1'b0;
			o_read_pattern    <= 1'b0;
			o_write_go        <= 1'b0;
		end else begin
			o_cmd_ready       <= next_ready;
			o_done            <= commit;
			o_check_condition <= next_check;
			o_read_go         <= next_read_go;
			o_read_pattern    <= next_read_pat;
			o_write_go        <= next_write_go;
		end
	end

	// Sense codes stand for the one cycle of o_done and are cleared otherwise.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_sense_key <= `ZC_SENSE_NONE;
			o_sense_asc <= `ZC_ASC_NONE;
		end else begin
			o_sense_key <= commit ? next_key : `ZC_SENSE_NONE;
			o_sense_asc <= commit ? next_asc : `ZC_ASC_NONE;
		end
	end

	// Descriptor fields are valid while o_done is high and show the state before the
	// update; afterwards they follow whatever zone the idle pins address.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_sense_info     <= '0;
			o_zone_condition <= `ZC_INIT_STATE;
			o_zone_wp        <= '0;
			o_zone_wp_valid  <= 1'b0;
		end else begin
			o_sense_info     <= cur_wp;
			o_zone_condition <= cur_state;
			o_zone_wp        <= cur_wp;
			o_zone_wp_valid  <= !is_full && start_seq;
		end
	end

	// The resource flag is constant, but it leaves through a flop like every other output.
	always_ff @(posedge i_clk or negedge rst_sync) begin
		if (!rst_sync) begin
			o_nonsequential_resource_flag <= 1'b0;
			o_open_count                  <= '0;
		end else begin
			o_nonsequential_resource_flag <= 1'b0;
			o_open_count                  <= next_open_count;
		end
	end
endmodule

//--- sim/zone_checker_properties.sv
`timescale 1ns/100ps
// Purpose: Port level checks on the zone write pointer checker.
// Assumes: A command is taken on an edge with valid and ready both high.
// Notes:   Sense codes other than invalid data are tied to key and status so a swapped code shows.
`include "zone_checker_regs.svh"
module zone_checker_properties #(
	parameter int ZW       = 4,
	parameter int MAX_OPEN = 4
) (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_cmd_valid,
	input wire logic        o_cmd_ready,
	input wire logic        o_done,
	input wire logic        o_check_condition,
	input wire logic [3:0]  o_sense_key,
	input wire logic [15:0] o_sense_asc,
	input wire logic        o_read_go,
	input wire logic        o_read_pattern,
	input wire logic        o_write_go,
	input wire logic        o_nonsequential_resource_flag,
	input wire logic [ZW:0] o_open_count
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	take_latency_a: assert property (i_cmd_valid && o_cmd_ready |-> ##4 o_done)
		else $error("Answer not four clocks after take.");
	done_pulse_a: assert property (o_done |=> !o_done)
		else $error("Done held longer than one clock.");
	nonseq_zero_a: assert property (o_nonsequential_resource_flag == 1'b0)
		else $error("Non-sequential flag set.");
	unaligned_key_a: assert property (o_done && o_sense_asc == `ZC_ASC_UNALIGNED
		|-> o_check_condition && o_sense_key == `ZC_SENSE_ILLEGAL)
		else $error("Unaligned sense without illegal request.");
	wr_bound_key_a: assert property (o_done && o_sense_asc == `ZC_ASC_WR_BOUNDARY
		|-> o_check_condition && o_sense_key == `ZC_SENSE_ILLEGAL)
		else $error("Write boundary sense without illegal request.");
	rd_bound_key_a: assert property (o_done && o_sense_asc == `ZC_ASC_RD_BOUNDARY
		|-> o_check_condition && o_sense_key == `ZC_SENSE_ILLEGAL)
		else $error("Read boundary sense without illegal request.");
	resource_key_a: assert property (o_done && o_sense_asc == `ZC_ASC_NO_RESOURCES
		|-> o_check_condition && o_sense_key == `ZC_SENSE_ABORTED && o_open_count == MAX_OPEN)
		else $error("Resource refusal below the open limit.");
	reject_nogo_a: assert property (o_done && o_check_condition
		|-> !o_write_go && !o_read_go)
		else $error("Refused command still started.");
	pattern_go_a: assert property (o_read_pattern |-> o_read_go && o_done)
		else $error("Pattern read without a started read.");
endmodule
bind zone_write_pointer_checker zone_checker_properties #(.ZW(ZW), .MAX_OPEN(MAX_OPEN)) props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
	.o_done(o_done), .o_check_condition(o_check_condition), .o_sense_key(o_sense_key),
	.o_sense_asc(o_sense_asc), .o_read_go(o_read_go), .o_write_go(o_write_go),
	.o_read_pattern(o_read_pattern),
	.o_nonsequential_resource_flag(o_nonsequential_resource_flag),
	.o_open_count(o_open_count));

//--- sim/host_model.sv
`timescale 1ns/100ps
// Purpose: Host that offers one command at a time.
// Assumes: The answer comes within twenty clocks.
// Notes:   Idle lines show inverted values, so a stale command cannot pass.
module host_model (
	input  wire logic  i_clk,
	input  wire logic  i_ready,
	input  wire logic  i_done,
	output logic       o_valid,
	output logic [2:0] o_op,
	output logic [11:0] o_lba,
	output logic [11:0] o_count
);
	initial begin
		o_valid = 1'b0;
		o_op = 3'h7;
		o_lba = 12'hFFF;
		o_count = 12'hFFF;
	end
	task automatic issue(input logic [2:0] op, input logic [11:0] lba, cnt);
		int n;
		@(posedge i_clk);
		#1;
		for (n = 0; n < 20 && i_ready !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		o_valid = 1'b1;
		o_op = op;
		o_lba = lba;
		o_count = cnt;
		@(posedge i_clk);
		#1 o_valid = 1'b0;
		for (n = 0; n < 20 && i_done !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		o_op = ~op;
		o_lba = ~lba;
		o_count = ~cnt;
	endtask
endmodule

//--- sim/tb.sv
`timescale 1ns/100ps
// Purpose: Self-checking bench for the zone write pointer checker.
// Assumes: Default parameters: 256-block zones, zone 0 conventional, limit of four open.
// Notes:   The open limit test runs right after the power-on reports, while no other zone is open.
`include "zone_checker_regs.svh"
module tb;
	import zone_checker_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        flag = 1'b0;
	logic        pv = 1'b0;
	logic        pf = 1'b0;
	logic [3:0]  pz = 4'h0;
	logic [11:0] pw = 12'h000;
	logic        cv, ready, done, chk, rgo, rpat, wgo, wpv, nsq;
	logic [2:0]  cop, cond;
	logic [3:0]  key;
	logic [15:0] asc;
	logic [11:0] clba, ccnt, info, wp;
	logic [4:0]  ocnt;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cycles = 0;
	always #10 clk = ~clk;
	host_model host (.i_clk(clk), .i_ready(ready), .i_done(done), .o_valid(cv), .o_op(cop),
		.o_lba(clba), .o_count(ccnt));
	zone_write_pointer_checker dut (.i_clk(clk), .i_rst_n(rst_n), .i_cmd_valid(cv),
		.i_cmd_op(cop), .i_cmd_lba(clba), .i_cmd_count(ccnt), .i_unrestricted_read_flag(flag),
		.i_preload_valid(pv), .i_preload_zone(pz), .i_preload_wp(pw), .i_preload_full(pf),
		.o_cmd_ready(ready), .o_done(done), .o_check_condition(chk), .o_sense_key(key),
		.o_sense_asc(asc), .o_sense_info(info), .o_read_go(rgo), .o_read_pattern(rpat),
		.o_write_go(wgo), .o_zone_condition(cond), .o_zone_wp(wp), .o_zone_wp_valid(wpv),
		.o_nonsequential_resource_flag(nsq), .o_open_count(ocnt));
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic cmp(input string n, input logic [15:0] e, g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	// The condition shown is the one held before the command's update.
	task automatic ok(input logic [2:0] op, c, input logic [11:0] a, n);
		host.issue(op, a, n);
		cmp("check", 16'h0, {15'h0, chk});
		cmp("cond", {13'h0, c}, {13'h0, cond});
		if (op == op_write) cmp("write go", 16'h1, {15'h0, wgo});
		if (op == op_read) cmp("read go", 16'h1, {15'h0, rgo});
	endtask
	// An info of FFF skips the pointer compare.
	task automatic err(input logic [2:0] op, input logic [11:0] a, n, i, input logic [15:0] s);
		host.issue(op, a, n);
		cmp("check", 16'h1, {15'h0, chk});
		cmp("asc", s, asc);
		if (i != 12'hFFF) cmp("info", {4'h0, i}, {4'h0, info});
	endtask
	task automatic rep(input logic [2:0] c, input logic [11:0] a, w);
		host.issue(op_report, a, 12'h001);
		cmp("cond", {13'h0, c}, {13'h0, cond});
		cmp("nonseq", 16'h0, {15'h0, nsq});
		cmp("wp valid", {15'h0, c != zone_state_full}, {15'h0, wpv});
		if (c != zone_state_full) cmp("wp", {4'h0, w}, {4'h0, wp});
	endtask
	task automatic t_power;
		rep(zone_state_empty, 12'h100, 12'h100);
		rep(zone_state_closed, 12'h600, 12'h610);
		rep(zone_state_full, 12'h700, 12'h000);
	endtask
	task automatic t_limit;
		for (int z = 8; z < 12; z++) ok(op_open, zone_state_empty, 12'(z * 256), 12'h1);
		cmp("open count", 16'h4, {11'h0, ocnt});
		err(op_write, 12'hC00, 12'h8, 12'hFFF, `ZC_ASC_NO_RESOURCES);
		for (int z = 8; z < 12; z++) ok(op_close, zone_state_host_opened, 12'(z * 256), 12'h1);
		rep(zone_state_empty, 12'h800, 12'h800);
	endtask
	task automatic t_write;
		ok(op_write, zone_state_empty, 12'h100, 12'h10);
		rep(zone_state_auto_opened, 12'h100, 12'h110);
		err(op_write, 12'h110, 12'h4, 12'h110, `ZC_ASC_UNALIGNED);
		err(op_write, 12'h120, 12'h8, 12'h110, `ZC_ASC_UNALIGNED);
		ok(op_close, zone_state_auto_opened, 12'h100, 12'h1);
		ok(op_close, zone_state_closed, 12'h100, 12'h1);
		ok(op_open, zone_state_closed, 12'h100, 12'h1);
		ok(op_open, zone_state_host_opened, 12'h100, 12'h1);
		ok(op_write, zone_state_host_opened, 12'h110, 12'hF0);
		err(op_write, 12'h100, 12'h8, 12'hFFF, `ZC_ASC_UNALIGNED);
		ok(op_close, zone_state_full, 12'h100, 12'h1);
		ok(op_finish, zone_state_full, 12'h100, 12'h1);
		ok(op_reset, zone_state_full, 12'h100, 12'h1);
		rep(zone_state_empty, 12'h100, 12'h100);
		ok(op_write, zone_state_closed, 12'h610, 12'h10);
		rep(zone_state_auto_opened, 12'h600, 12'h620);
		ok(op_finish, zone_state_auto_opened, 12'h600, 12'h1);
		rep(zone_state_full, 12'h600, 12'h000);
		err(op_write, 12'h200, 12'h108, 12'h200, `ZC_ASC_WR_BOUNDARY);
		err(op_write, 12'h0F8, 12'h10, 12'hFFF, `ZC_ASC_WR_BOUNDARY);
	endtask
	task automatic t_read;
		err(op_read, 12'h300, 12'h1, 12'h300, `ZC_ASC_INVALID_DATA);
		ok(op_write, zone_state_empty, 12'h300, 12'h10);
		ok(op_read, zone_state_auto_opened, 12'h300, 12'h8);
		err(op_read, 12'h3F0, 12'h20, 12'hFFF, `ZC_ASC_RD_BOUNDARY);
		err(op_read, 12'h0F0, 12'h20, 12'hFFF, `ZC_ASC_INVALID_DATA);
		flag = 1'b1;
		ok(op_read, zone_state_auto_opened, 12'h308, 12'h10);
		cmp("pattern", 16'h1, {15'h0, rpat});
		ok(op_read, zone_state_auto_opened, 12'h3F0, 12'h20);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk);
		for (int z = 0; z < 16; z++) begin
			#1 pv = 1'b1;
			pz = 4'(z);
			pw = (z == 6) ? 12'h610 : (z == 7) ? 12'h7FF : 12'(z * 256);
			pf = (z == 7);
			@(posedge clk);
		end
		#1 pv = 1'b0;
		t_power();
		t_limit();
		t_write();
		t_read();
		summarize();
	end
endmodule
